// ### shared/cpu_wait_map.svh
`ifndef CPU_WAIT_MAP_SVH
`define CPU_WAIT_MAP_SVH

// Wait lengths in periods of the high-frequency clock
`define WAIT_LONG_EXP       10
`define WAIT_SHORT_EXP      3
`define WAIT_LONG_CYCLES    11'h400
`define WAIT_SHORT_CYCLES   11'h008
`define WAIT_CNT_W          11

// Target mode codes on wake_target
`define TARGET_NORMAL       1'b0
`define TARGET_SLOW         1'b1

// Source mode codes on wake_source
`define SRC_STOP            2'h0
`define SRC_IDLE            2'h1
`define SRC_SLEEP           2'h2

`define IRQ_W               16

`endif

// ### shared/cpu_wait_pkg.sv
`default_nettype none
package cpu_wait_pkg;
   typedef enum logic [1:0] {
      st_reset_wait = 2'b00,
      st_run        = 2'b01,
      st_wake_wait  = 2'b10
   } wait_state_t;
endpackage
`default_nettype wire

// ### rtl/cpu_wait_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpu_wait_map.svh"

// Notes on behaviour
// R1: STOP to NORMAL, control 1: 1024 cycles
// R2: STOP to SLOW, control 1: 8 cycles
// R3: Idle to NORMAL, control 0: 1024 cycles
// R4: Sleep to SLOW, control 0: 8 cycles
// R5: Wake waits halt CPU, peripherals run
// R6: Interrupts latch during wake waits
// R7: Latched interrupts serviced only after wait
// R8: Reset wait holds CPU and peripherals 1024
module cpu_wait_sequencer
   import cpu_wait_pkg::*;
(
   // Clock and reset (high_freq_clock)
   input  wire logic                  sys_clk,
   input  wire logic                  rst_n,
   // Wake request from the mode controller
   input  wire logic                  wake_req,
   input  wire logic [1:0]            wake_source,
   input  wire logic                  wake_target,
   input  wire logic                  nvm_power_down,
   // Interrupt side
   input  wire logic [`IRQ_W-1:0]     irq_req,
   input  wire logic [`IRQ_W-1:0]     irq_clear,
   input  wire logic                  master_interrupt_enable,
   // Hold, done and interrupt outputs
   output logic                       cpu_hold,
   output logic                       periph_hold,
   output logic                       wait_done,
   output logic [`IRQ_W-1:0]          interrupt_pending_latch,
   output logic                       irq_accept
);

   // State and wait counter
   wait_state_t                 state;
   wait_state_t                 next_state;
   logic [`WAIT_CNT_W-1:0]      count;
   logic [`WAIT_CNT_W-1:0]      next_count;
   wire logic [`WAIT_CNT_W-1:0] count_dec;
   wire logic [`WAIT_CNT_W-1:0] wake_len;
   wire logic                   count_last;
   wire logic                   in_wait;

   // Wake decode
   wire logic                   src_stop;
   wire logic                   src_idle;
   wire logic                   src_sleep;
   wire logic                   to_normal;
   wire logic                   to_slow;
   wire logic                   stop_long;
   wire logic                   stop_short;
   wire logic                   idle_long;
   wire logic                   sleep_short;
   wire logic                   wake_long;
   wire logic                   wake_short;
   wire logic                   wake_valid;
   wire logic                   wake_taken;

   // Registered outputs and their next values
   logic                        wait_done_q;
   wire logic                   next_cpu_hold;
   wire logic                   next_periph_hold;
   wire logic                   next_wait_done;

   // Interrupt latch terms, one bit per source, then the acceptance terms
   wire logic [`IRQ_W-1:0]      latch_set;
   wire logic [`IRQ_W-1:0]      latch_clear;
   wire logic [`IRQ_W-1:0]      next_latch;
   wire logic                   any_pending;
   wire logic                   cpu_running;

   // Where the core is waking from and where it is going
   assign src_stop    = wake_source == `SRC_STOP;
   assign src_idle    = wake_source == `SRC_IDLE;
   assign src_sleep   = wake_source == `SRC_SLEEP;
   assign to_normal   = wake_target == `TARGET_NORMAL;
   assign to_slow     = wake_target == `TARGET_SLOW;

   // Pick the wait length from source, target and control bit
   assign stop_long   = src_stop && nvm_power_down && to_normal;     // R1
   assign stop_short  = src_stop && nvm_power_down && to_slow;       // R2
   assign idle_long   = src_idle && !nvm_power_down && to_normal;    // R3
   assign sleep_short = src_sleep && !nvm_power_down && to_slow;     // R4
   assign wake_long   = stop_long || idle_long;
   assign wake_short  = stop_short || sleep_short;
   assign wake_len    = wake_long ? `WAIT_LONG_CYCLES : `WAIT_SHORT_CYCLES;

   // Combinations outside the table wake with no wait at all
   assign wake_valid  = wake_req && (wake_long || wake_short);
   // A request seen during a wait is dropped, not queued
   assign wake_taken  = !in_wait && wake_valid;

   // Eleven bits hold the long count; it runs down to zero and rests there until reloaded
   assign count_dec   = count - `WAIT_CNT_W'(1);
   assign count_last  = count == `WAIT_CNT_W'(1);
   assign in_wait     = state != st_run;

   // Next state
   always_comb begin
      next_state = state;
      case (state)
         st_reset_wait: begin
            if (count_last) begin
               next_state = st_run;                             // R8
            end
         end
         st_run: begin
            if (wake_taken) begin
               next_state = st_wake_wait;
            end
         end
         st_wake_wait: begin
            if (count_last) begin
               next_state = st_run;
            end
         end
         default: begin
            next_state = st_reset_wait;
         end
      endcase
   end

   // Wait counter: loaded on a taken wake, runs down in either wait
   always_comb begin
      next_count = count;
      case (state)
         st_reset_wait: begin
            next_count = count_dec;
         end
         st_run: begin
            if (wake_taken) begin
               next_count = wake_len;                           // R1 R2 R3 R4
            end
         end
         st_wake_wait: begin
            next_count = count_dec;
         end
         default: begin
            next_count = `WAIT_LONG_CYCLES;
         end
      endcase
   end

   // State register
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= st_reset_wait;
      end else begin
         state <= next_state;
      end
   end

   // Reset starts the long count straight away
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= `WAIT_LONG_CYCLES;                            // R8
      end else begin
         count <= next_count;
      end
   end

   // Holds follow the state being entered, so they move with it
   assign next_cpu_hold    = next_state != st_run;              // R5
   assign next_periph_hold = next_state == st_reset_wait;       // R5
   assign next_wait_done   = in_wait && next_state == st_run;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cpu_hold <= 1'b1;
      end else begin
         cpu_hold <= next_cpu_hold;                             // R5
      end
   end

   // Peripherals halt only in the wait that follows reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         periph_hold <= 1'b1;                                   // R8
      end else begin
         periph_hold <= next_periph_hold;                       // R5
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_done_q <= 1'b0;
      end else begin
         wait_done_q <= next_wait_done;
      end
   end

   assign wait_done = wait_done_q;

   // Set beats clear, so a request on the clearing edge is kept
   // Nothing latches in the reset wait, while peripherals are stopped
   genvar i;
   generate
      for (i = 0; i < `IRQ_W; i = i + 1) begin : g_latch
         assign latch_set[i]   = irq_req[i] && !periph_hold;    // R6
         assign latch_clear[i] = irq_clear[i];
         assign next_latch[i]  = latch_set[i]
                                 || (interrupt_pending_latch[i]
                                     && !latch_clear[i]);
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         interrupt_pending_latch <= '0;
      end else begin
         interrupt_pending_latch <= next_latch;                 // R6
      end
   end

   // Acceptance only once the CPU runs again
   assign any_pending = |interrupt_pending_latch;
   assign cpu_running = !cpu_hold;
   assign irq_accept  = cpu_running && master_interrupt_enable
                        && any_pending;                         // R7

endmodule
`default_nettype wire

// ### bench/cpu_wait_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpu_wait_map.svh"
module cpu_wait_monitor (
   // Clock and reset
   input wire logic              sys_clk,
   input wire logic              rst_n,
   // Wake request
   input wire logic              wake_req,
   input wire logic [1:0]        wake_source,
   input wire logic              wake_target,
   input wire logic              nvm_power_down,
   // Interrupt side
   input wire logic [`IRQ_W-1:0] irq_req,
   input wire logic              master_interrupt_enable,
   input wire logic [`IRQ_W-1:0] interrupt_pending_latch,
   input wire logic              irq_accept,
   // Holds
   input wire logic              cpu_hold,
   input wire logic              periph_hold,
   input wire logic              wait_done
);
   logic [10:0] cnt, exp;
   wire pd = nvm_power_down;
   wire go = wake_req & !cpu_hold & (wake_source == `SRC_STOP ? pd : !pd &
      (wake_source == (wake_target ? `SRC_SLEEP : `SRC_IDLE)));
   // Hold length is measured, so any off-by-one in the counter shows
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
         exp <= `WAIT_LONG_CYCLES;
      end else begin
         cnt <= cpu_hold ? cnt + 11'h1 : '0;
         exp <= !go ? exp : wake_target ? 11'h8 : 11'h400;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_done;
      wait_done ##1 !wait_done;
   endsequence
   a_wait_len: assert property ($fell(cpu_hold) |-> cnt == exp)
      else $error("wait length wrong");
   a_done_pulse: assert property ($fell(cpu_hold) |-> s_done)
      else $error("done pulse wrong");
   a_wake_start: assert property (go |=> cpu_hold && !periph_hold)
      else $error("wake wait wrong");
   a_periph_run: assert property (!periph_hold |=> !periph_hold)
      else $error("peripherals halted");
   a_irq_latch: assert property (|irq_req && !periph_hold |=>
      (interrupt_pending_latch & $past(irq_req)) == $past(irq_req))
      else $error("request not latched");
   a_accept_hold: assert property (cpu_hold |-> !irq_accept)
      else $error("accept during wait");
   a_accept_run: assert property (!cpu_hold && master_interrupt_enable &&
      |interrupt_pending_latch |-> irq_accept) else $error("no accept");
   a_reset_wait: assert property ($fell(periph_hold) |->
      $fell(cpu_hold) && cnt == `WAIT_LONG_CYCLES) else $error("reset wait");
endmodule
bind cpu_wait_sequencer cpu_wait_monitor mon (
   .sys_clk                 (sys_clk),
   .rst_n                   (rst_n),
   .wake_req                (wake_req),
   .wake_source             (wake_source),
   .wake_target             (wake_target),
   .nvm_power_down          (nvm_power_down),
   .irq_req                 (irq_req),
   .master_interrupt_enable (master_interrupt_enable),
   .interrupt_pending_latch (interrupt_pending_latch),
   .irq_accept              (irq_accept),
   .cpu_hold                (cpu_hold),
   .periph_hold             (periph_hold),
   .wait_done               (wait_done)
);
`default_nettype wire

// ### bench/cpu_wait_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpu_wait_map.svh"
module cpu_wait_sequencer_test;
   logic sys_clk = 0, rst_n = 0, wake_req = 0, wake_target = 0;
   logic nvm_power_down = 0, master_interrupt_enable = 0;
   logic cpu_hold, periph_hold, wait_done, irq_accept;
   logic [1:0] wake_source = 0;
   logic [15:0] irq_req = 0, irq_clear = 0, r, interrupt_pending_latch;
   int failures = 0, tests_run = 0, seed = 77, n;
   always #2 sys_clk = ~sys_clk;
   cpu_wait_sequencer dut (
      .sys_clk                 (sys_clk),
      .rst_n                   (rst_n),
      .wake_req                (wake_req),
      .wake_source             (wake_source),
      .wake_target             (wake_target),
      .nvm_power_down          (nvm_power_down),
      .irq_req                 (irq_req),
      .irq_clear               (irq_clear),
      .master_interrupt_enable (master_interrupt_enable),
      .cpu_hold                (cpu_hold),
      .periph_hold             (periph_hold),
      .wait_done               (wait_done),
      .interrupt_pending_latch (interrupt_pending_latch),
      .irq_accept              (irq_accept)
   );
   function logic [10:0] exp_len(logic [1:0] s, logic p, logic t);
      if (s == `SRC_STOP && p) return t ? 11'h8 : 11'h400;
      if (s == (t ? `SRC_SLEEP : `SRC_IDLE) && !p) return t ? 11'h8 : 11'h400;
      return '0;
   endfunction
   task chk(string w, logic [15:0] e, logic [15:0] g);
      tests_run++;
      if (e !== g) begin
         failures++;
         $display("BAD %s exp %h got %h", w, e, g);
      end
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Bounded so a stuck hold ends the run instead of hanging it
   task count_hold;
      n = 0;
      while (cpu_hold === 1'b1) begin
         n++;
         if (n == 2) chk("accept", 0, irq_accept);
         if (n > 1100) begin
            failures++;
            conclude;
         end
         @(posedge sys_clk);
         irq_req <= '0;
         #1;
      end
   endtask
   task wake(logic [1:0] s, logic p, logic t);
      r = 16'($random(seed));
      @(posedge sys_clk);
      {wake_req, wake_source, nvm_power_down, wake_target} <= {1'b1, s, p, t};
      {irq_clear, irq_req, master_interrupt_enable} <= {16'hffff, 16'h0, r[9]};
      @(posedge sys_clk);
      {wake_req, irq_clear, irq_req} <= {17'h0, r};
      #1;
      count_hold;
      chk("len", 16'(exp_len(s, p, t)), 16'(n));
      chk("done", 16'(exp_len(s, p, t) != 0), 16'(wait_done));
      chk("periph", 0, 16'(periph_hold));
      @(posedge sys_clk);
      #1;
      chk("latch", r, interrupt_pending_latch);
      chk("take", 16'(r[9] & |r), 16'(irq_accept));
   endtask
   initial begin
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      #1;
      count_hold;
      chk("reset", 16'h400, 16'(n));
      chk("reset done", 16'h1, 16'(wait_done));
      $display("test reset done");
      for (int i = 0; i < 16; i++) begin
         wake(2'(i >> 2), i[1], i[0]);
         $display("test %0d done", i);
      end
      conclude;
   end
endmodule
`default_nettype wire
